// file: ssgc_pkg.sv
// shared constants, field positions and types of the serial select / trigger-sync channel
package ssgc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RD_W   = 16;
  // register word indices
  localparam logic [ADDR_W-1:0] A_TX_BUFFER  = 4'h0;
  localparam logic [ADDR_W-1:0] A_RX_BUFFER  = 4'h1;
  localparam logic [ADDR_W-1:0] A_BIT_RATE   = 4'h2;
  localparam logic [ADDR_W-1:0] A_CH_MODE    = 4'h3;
  localparam logic [ADDR_W-1:0] A_CH_CTRL0   = 4'h4;
  localparam logic [ADDR_W-1:0] A_CH_CTRL1   = 4'h5;
  localparam logic [ADDR_W-1:0] A_SPECIAL1   = 4'h6;
  localparam logic [ADDR_W-1:0] A_SPECIAL2   = 4'h7;
  localparam logic [ADDR_W-1:0] A_SPECIAL3   = 4'h8;
  localparam logic [ADDR_W-1:0] A_SPECIAL4   = 4'h9;
  // channel_mode fields
  localparam int MR_MODE_LSB   = 0;
  localparam int MR_CLK_SRC    = 3;
  localparam logic [2:0] MODE_CLK_SYNC = 3'h1;
  // channel_control_0 fields
  localparam int C0_SHIFT_REGISTER_EMPTY_FLAG      = 3;
  localparam int C0_OPEN_DRAIN = 5;
  localparam int C0_CPOL       = 6;
  localparam int C0_MSB_FIRST  = 7;
  // channel_control_1 fields
  localparam int C1_TE         = 0;
  localparam int C1_TBE        = 1;
  localparam int C1_RE         = 2;
  localparam int C1_RI         = 3;
  localparam int C1_IRS        = 4;
  localparam int C1_CLK_STOP   = 7;
  // special mode fields and receive buffer overrun bit
  localparam int S1_HALVING    = 7;
  localparam int S2_SYNC_EN    = 6;
  localparam int S3_SSE        = 0;
  localparam int S3_CPHA       = 1;
  localparam int S3_FAULT      = 2;
  localparam int S3_SLAVE      = 3;
  localparam int RB_OVERRUN    = 12;
  // reset values
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] RST_C0   = 8'h08;
  localparam logic [7:0] RST_C1   = 8'h02;
  // transfer framing: two clock edges per bit
  localparam logic [4:0] EDGES_PER_CHAR = 5'h10;
  localparam logic [3:0] OVERRUN_BIT    = 4'h7;
  localparam logic [7:0] DIV_ZERO       = 8'h00;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } ssgc_state_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ssgc_pad_t;
endpackage

// file: ssgc_sync.sv
// two-flop synchroniser for pins that come from outside the core clock domain
`timescale 1ns/10ps
module ssgc_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: ssgc_channel.sv
// serial channel with slave-select mode, fault detection and trigger-synchronised clock mode
// How it works
// - select-enable bit set to 1 enters slave-select mode and activates select pin.
// - master/slave bit 1 makes a slave, 0 a master in select mode.
// - slave with select high floats its data pins and ignores clock edges.
// - slave with select low accepts the clock and communicates.
// - master with select high may transfer and drives the clock pin.
// - master sees select low: floats data out and clock, sets fault flag.
// - fault flag cleared while select high re-enables the master outputs.
// - phase bit and polarity bit pick one of four clock shapes.
// - slave phase 0: output undefined until clock edges, then follows clock.
// - slave phase 1: first bit driven as soon as select goes low.
// - trigger-synchronised mode moves eight-bit characters.
// - trigger-synchronised mode uses the external clock pin.
// - trigger mode starts after enables set, data loaded, then trigger pulse.
// - source select 0: transmit request when buffer moves to shift register.
// - source select 1: transmit request when shifting out finishes.
// - receive request when a character moves into the receive buffer.
// - overrun when seventh bit of next character arrives before buffer read.
// - after overrun no receive request for that character.
// - sync bits: none, external rate, or half the external rate.
// - clock run bit starts or stops the derived clock in external mode.
`timescale 1ns/10ps
module ssgc_channel (
  // clock, reset, enable
  input  wire logic                            core_clk,
  input  wire logic                            rstn,
  input  wire logic                            ce,
  // register port
  input  wire logic [ssgc_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [ssgc_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [ssgc_pkg::RD_W-1:0]       reg_rdata,
  // select and trigger pins
  input  wire logic                            slave_select_pin_n,
  input  wire logic                            trigger_input_pin_n,
  // transfer clock pad
  input  wire logic                            transfer_clock_pin_i,
  output ssgc_pkg::ssgc_pad_t                  transfer_clock_pin_o,
  // pad a: master data out / slave data in
  input  wire logic                            slave_serial_in,
  output ssgc_pkg::ssgc_pad_t                  master_serial_out,
  // pad b: master data in / slave data out
  input  wire logic                            master_serial_in,
  output ssgc_pkg::ssgc_pad_t                  slave_serial_out,
  // interrupt requests
  output logic                                 tx_irq,
  output logic                                 rx_irq
);
  logic [7:0] tb_q, brg_q, mr_q, c0_q, c1_q, smr1_q, smr2_q, smr3_q, smr4_q, rb_q;
  logic       tbe_q, ri_q, ovr_q, fault_q, rb_unread_q, ovr_pend_q;
  logic       ss_s, trg_s, clk_s, sin_a, sin_b;
  logic       trg_prev_q, ext_prev_q, clk_prev_q, dclk_q, armed_q, mclk_q, out_q;
  logic [7:0] sh_q, div_q;
  logic [4:0] ecnt_q;
  logic [3:0] scnt_q;
  ssgc_pkg::ssgc_state_t state_q;

  ssgc_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .d        ({slave_select_pin_n, trigger_input_pin_n, transfer_clock_pin_i,
                slave_serial_in, master_serial_in}),
    .q        ({ss_s, trg_s, clk_s, sin_a, sin_b})
  );

  function automatic logic first_bit(input logic [7:0] v, input logic msb);
    first_bit = msb ? v[7] : v[0];
  endfunction

  function automatic logic wr_at(input logic [ssgc_pkg::ADDR_W-1:0] a);
    wr_at = reg_wr && (reg_addr == a);
  endfunction

  // configuration decode
  logic slave_select_function_enable, slave, cpol, cpha, msb, te, re, irs, ext_src, gci, sync_on, halving;
  assign slave_select_function_enable     = smr3_q[ssgc_pkg::S3_SSE];
  assign ext_src = mr_q[ssgc_pkg::MR_CLK_SRC];
  assign slave   = slave_select_function_enable ? smr3_q[ssgc_pkg::S3_SLAVE] : ext_src;
  assign cpol    = c0_q[ssgc_pkg::C0_CPOL];
  assign cpha    = smr3_q[ssgc_pkg::S3_CPHA];
  assign msb     = c0_q[ssgc_pkg::C0_MSB_FIRST];
  assign te      = c1_q[ssgc_pkg::C1_TE];
  assign re      = c1_q[ssgc_pkg::C1_RE];
  assign irs     = c1_q[ssgc_pkg::C1_IRS];
  assign halving = smr1_q[ssgc_pkg::S1_HALVING];
  assign sync_on = halving || smr2_q[ssgc_pkg::S2_SYNC_EN];
  // trigger mode: external clock plus a sync selection, select function off
  assign gci = !slave_select_function_enable && ext_src && sync_on
            && (mr_q[2:0] == ssgc_pkg::MODE_CLK_SYNC);

  // a master stays off the wires while a fault is pending
  logic m_quiet;
  assign m_quiet = slave_select_function_enable && fault_q;

  // start of a character
  logic load, may_start;
  always_comb begin
    if (!slave)
      may_start = slave_select_function_enable ? (ss_s && !fault_q) : 1'b1;
    else if (gci)
      may_start = armed_q && re;
    else
      may_start = 1'b1;
  end
  assign load = (state_q == ssgc_pkg::ST_IDLE) && te && !tbe_q && may_start;

  // trigger: falling edge of the synchronised pin arms the derived clock
  logic trg_fall;
  assign trg_fall = !trg_s && trg_prev_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      trg_prev_q <= 1'b0;
      armed_q    <= 1'b0;
    end else if (ce) begin
      trg_prev_q <= trg_s;
      if (!gci || !te)
        armed_q <= 1'b0;
      else if (trg_fall && re && !tbe_q)
        armed_q <= 1'b1;
    end
  end

  // derived clock: follows or halves the external clock once armed
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dclk_q <= 1'b0;
    end else if (ce) begin
      if (!armed_q)
        dclk_q <= cpol;
      else if (c1_q[ssgc_pkg::C1_CLK_STOP])
        dclk_q <= dclk_q;
      else if (halving)
        dclk_q <= (clk_s && !clk_prev_q) ? !dclk_q : dclk_q;
      else
        dclk_q <= clk_s;
    end
  end

  // edge generation: internal divider for a master, pin for a slave
  logic ext_lvl, ext_en, tog, edge_ev, new_lvl, lead, sample_ev, shift_ev, done;
  assign ext_lvl = gci ? dclk_q : clk_s;
  assign ext_en  = slave_select_function_enable ? !ss_s : (!gci || armed_q);
  assign tog     = (state_q == ssgc_pkg::ST_RUN) && !slave && (div_q == ssgc_pkg::DIV_ZERO);
  always_comb begin
    if (!slave) begin
      edge_ev = tog;
      new_lvl = !mclk_q;
    end else begin
      edge_ev = (state_q == ssgc_pkg::ST_RUN) && ext_en && (ext_lvl != ext_prev_q);
      new_lvl = ext_lvl;
    end
  end
  assign lead      = edge_ev && (new_lvl != cpol);
  assign sample_ev = cpha ? lead : (edge_ev && !lead);
  assign shift_ev  = cpha ? (edge_ev && !lead) : lead;
  assign done      = edge_ev && (ecnt_q == ssgc_pkg::EDGES_PER_CHAR - 5'h01);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ext_prev_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end else if (ce) begin
      // raw pin history kept apart so the halver never compares against the derived level
      ext_prev_q <= ext_lvl;
      clk_prev_q <= clk_s;
    end
  end

  // master clock divider, half period is divider value plus one
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_q  <= ssgc_pkg::DIV_ZERO;
      mclk_q <= 1'b0;
    end else if (ce) begin
      if (state_q != ssgc_pkg::ST_RUN || slave) begin
        div_q  <= brg_q;
        mclk_q <= cpol;
      end else if (tog) begin
        div_q  <= brg_q;
        mclk_q <= !mclk_q;
      end else begin
        div_q  <= div_q - 8'h01;
      end
    end
  end

  // shift engine
  logic abort;
  assign abort = slave_select_function_enable && !slave && !ss_s;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ssgc_pkg::ST_IDLE;
      sh_q    <= ssgc_pkg::RST_REG;
      ecnt_q  <= 5'h00;
      scnt_q  <= 4'h0;
      out_q   <= 1'b1;
    end else if (ce) begin
      if (load) begin
        state_q <= ssgc_pkg::ST_RUN;
        sh_q    <= tb_q;
        ecnt_q  <= 5'h00;
        scnt_q  <= 4'h0;
        if (cpha)
          out_q <= first_bit(tb_q, msb);
      end else if (state_q == ssgc_pkg::ST_RUN) begin
        if (abort || done)
          state_q <= ssgc_pkg::ST_IDLE;
        if (edge_ev)
          ecnt_q <= ecnt_q + 5'h01;
        if (shift_ev)
          out_q <= first_bit(sh_q, msb);
        if (sample_ev) begin
          scnt_q <= scnt_q + 4'h1;
          sh_q   <= msb ? {sh_q[6:0], slave ? sin_a : sin_b}
                        : {slave ? sin_a : sin_b, sh_q[7:1]};
        end
      end
    end
  end

  // receive completion and overrun
  logic samp_in, rx_cmp, ovr_ev;
  assign samp_in = slave ? sin_a : sin_b;
  assign ovr_ev  = sample_ev && re && rb_unread_q
                && (scnt_q + 4'h1 == ssgc_pkg::OVERRUN_BIT);
  assign rx_cmp  = done && re && !ovr_pend_q;

  logic rb_rd;
  assign rb_rd = reg_rd && (reg_addr == ssgc_pkg::A_RX_BUFFER);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rb_q        <= ssgc_pkg::RST_REG;
      ri_q        <= 1'b0;
      ovr_q       <= 1'b0;
      rb_unread_q <= 1'b0;
      ovr_pend_q  <= 1'b0;
    end else if (ce) begin
      // phase 1 took its last sample on the leading edge, so no extra shift here
      if (done && re)
        rb_q <= cpha ? sh_q
                     : (msb ? {sh_q[6:0], samp_in} : {samp_in, sh_q[7:1]});
      if (load)
        ovr_pend_q <= 1'b0;
      else if (ovr_ev)
        ovr_pend_q <= 1'b1;
      // set wins over a same-cycle read or clear
      if (rx_cmp)
        ri_q <= 1'b1;
      else if (rb_rd)
        ri_q <= 1'b0;
      if (rx_cmp)
        rb_unread_q <= 1'b1;
      else if (rb_rd)
        rb_unread_q <= 1'b0;
      if (ovr_ev)
        ovr_q <= 1'b1;
      else if (wr_at(ssgc_pkg::A_CH_CTRL1) && !reg_wdata[ssgc_pkg::C1_RE])
        ovr_q <= 1'b0;
    end
  end

  // software registers and buffer-empty flag
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tb_q   <= ssgc_pkg::RST_REG;
      brg_q  <= ssgc_pkg::RST_REG;
      mr_q   <= ssgc_pkg::RST_REG;
      c0_q   <= ssgc_pkg::RST_C0;
      c1_q   <= ssgc_pkg::RST_C1;
      smr1_q <= ssgc_pkg::RST_REG;
      smr2_q <= ssgc_pkg::RST_REG;
      smr3_q <= ssgc_pkg::RST_REG;
      smr4_q <= ssgc_pkg::RST_REG;
      tbe_q  <= 1'b1;
    end else if (ce) begin
      if (wr_at(ssgc_pkg::A_TX_BUFFER))
        tb_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_BIT_RATE))
        brg_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_CH_MODE))
        mr_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_CH_CTRL0))
        c0_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_CH_CTRL1))
        c1_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_SPECIAL1))
        smr1_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_SPECIAL2))
        smr2_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_SPECIAL3))
        smr3_q <= reg_wdata;
      if (wr_at(ssgc_pkg::A_SPECIAL4))
        smr4_q <= reg_wdata;
      // a write in the load cycle brings fresh data, so it wins
      if (wr_at(ssgc_pkg::A_TX_BUFFER))
        tbe_q <= 1'b0;
      else if (load)
        tbe_q <= 1'b1;
    end
  end

  // fault flag: write-clearable only while select is high, set wins; turning the select function off clears it at any level
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (ce) begin
      if (!slave_select_function_enable)
        fault_q <= 1'b0;
      else if (!slave && !ss_s)
        fault_q <= 1'b1;
      else if (wr_at(ssgc_pkg::A_SPECIAL3) && !reg_wdata[ssgc_pkg::S3_FAULT] && ss_s)
        fault_q <= 1'b0;
    end
  end

  // read data, one cycle after the strobe
  logic [ssgc_pkg::RD_W-1:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      ssgc_pkg::A_RX_BUFFER: begin
        rdata_d[7:0]                  = rb_q;
        rdata_d[ssgc_pkg::RB_OVERRUN] = ovr_q;
      end
      ssgc_pkg::A_CH_MODE:  rdata_d[7:0] = mr_q;
      ssgc_pkg::A_CH_CTRL0: begin
        rdata_d[7:0]                 = c0_q;
        rdata_d[ssgc_pkg::C0_SHIFT_REGISTER_EMPTY_FLAG]  = (state_q == ssgc_pkg::ST_IDLE);
      end
      ssgc_pkg::A_CH_CTRL1: begin
        rdata_d[7:0]               = c1_q;
        rdata_d[ssgc_pkg::C1_TBE]  = tbe_q;
        rdata_d[ssgc_pkg::C1_RI]   = ri_q;
      end
      ssgc_pkg::A_SPECIAL1: rdata_d[7:0] = smr1_q;
      ssgc_pkg::A_SPECIAL2: rdata_d[7:0] = smr2_q;
      ssgc_pkg::A_SPECIAL3: begin
        rdata_d[7:0]                = smr3_q;
        rdata_d[ssgc_pkg::S3_FAULT] = fault_q;
      end
      ssgc_pkg::A_SPECIAL4: rdata_d[7:0] = smr4_q;
      default:              rdata_d = '0;
    endcase
  end

  // registered pin drive; open-drain mode only ever pulls pad a (master data out) low, clock and pad b still drive both levels
  ssgc_pkg::ssgc_pad_t clk_d, mso_d, sso_d;
  logic mso_oe;
  assign mso_oe  = (!slave_select_function_enable || !slave) && !m_quiet;
  assign clk_d   = '{o: mclk_q, oe: !slave && !m_quiet};
  assign mso_d   = '{o: c0_q[ssgc_pkg::C0_OPEN_DRAIN] ? 1'b0 : out_q,
                     oe: mso_oe && (!c0_q[ssgc_pkg::C0_OPEN_DRAIN] || !out_q)};
  assign sso_d   = '{o: out_q, oe: slave_select_function_enable && slave && !ss_s};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      transfer_clock_pin_o <= '0;
      master_serial_out    <= '0;
      slave_serial_out     <= '0;
      reg_rdata            <= '0;
      tx_irq               <= 1'b0;
      rx_irq               <= 1'b0;
    end else if (ce) begin
      transfer_clock_pin_o <= clk_d;
      master_serial_out    <= mso_d;
      slave_serial_out     <= sso_d;
      if (reg_rd)
        reg_rdata <= rdata_d;
      tx_irq <= irs ? done : load;
      rx_irq <= rx_cmp;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn || !ce);

  chk_fault_sets: assert property (slave_select_function_enable && !slave && !ss_s |=> fault_q)
    else $error("fault flag not set by low select in master mode");
  chk_fault_floats: assert property (fault_q && slave_select_function_enable |=> !transfer_clock_pin_o.oe
                                       && !master_serial_out.oe)
    else $error("master still drives pins during fault");
  chk_fault_holds: assert property (fault_q && slave_select_function_enable && !ss_s |=> fault_q)
    else $error("fault flag cleared while select low");
  chk_slave_float: assert property (slave_select_function_enable && slave && ss_s |=> !slave_serial_out.oe)
    else $error("slave drives data out while deselected");
  chk_slave_ignore: assert property (slave_select_function_enable && slave && ss_s && state_q == ssgc_pkg::ST_RUN
                                     |=> $stable(ecnt_q))
    else $error("deselected slave counted a clock edge");
  chk_phase1_first: assert property (load && cpha
                                     |=> out_q == $past(first_bit(tb_q, msb)))
    else $error("first bit not presented at load with phase 1");
  chk_tx_irq_src: assert property (load && !irs |=> tx_irq ##1 !tx_irq || load)
    else $error("transmit request missing at buffer transfer");
  chk_tx_irq_done: assert property (done && irs |=> tx_irq)
    else $error("transmit request missing at shift end");
  chk_rx_request: assert property (done && re && !ovr_pend_q |=> rx_irq && ri_q)
    else $error("receive request missing after character");
  chk_ovr_no_irq: assert property (done && ovr_pend_q |=> !rx_irq && ovr_q)
    else $error("receive request raised on overrun");
  localparam logic [3:0] BITS_PER_CHAR = 4'h8;
  chk_char_bits: assert property (done |-> scnt_q + {3'h0, sample_ev} == BITS_PER_CHAR)
    else $error("character did not have eight bits");
  chk_gci_arm: assert property (gci && !armed_q && !trg_fall |=> !armed_q)
    else $error("trigger mode armed without trigger");

  cov_fault: cover property (slave_select_function_enable && !slave && $rose(fault_q));
  cov_overrun: cover property ($rose(ovr_q));
  cov_gci_char: cover property (gci && done);
  cov_slave_ph1: cover property (slave_select_function_enable && slave && cpha && done);
endmodule

// file: ssgc_peer.sv
// behavioural peer slave: lsb first, drives on leading edge, samples on trailing
`timescale 1ns/10ps
module ssgc_peer (
  // line side
  input  wire logic       sclk,
  input  wire logic       mosi,
  output logic            miso,
  // bench side
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_q
);
  logic [2:0] idx_q = 3'h0;
  initial miso = 1'b0;
  initial rx_q = 8'h00;
  // idle-low clock, same polarity and phase as the device master
  always @(posedge sclk) begin
    miso  <= tx_byte[idx_q];
    idx_q <= idx_q + 3'h1;
  end
  always @(negedge sclk) begin
    rx_q <= {mosi, rx_q[7:1]};
  end
endmodule

// file: testbench.sv
// self-checking bench of the serial channel with a peer slave model
`timescale 1ns/10ps
module testbench;
  logic        core_clk, rstn, reg_wr, reg_rd, sel_n, trg_n, bclk, sdi, miso;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, peer_tx, peer_rx, t, a, cap;
  logic [15:0] reg_rdata, v;
  logic [31:0] seed = 32'h61;
  int          fail_count = 0, num_checks = 0, txn = 0, rxn = 0, r0;
  ssgc_pkg::ssgc_pad_t clk_pad, mso_pad, sso_pad;
  logic        tx_irq, rx_irq;
  // released pads carry what the far end drives
  wire line_clk = clk_pad.oe ? clk_pad.o : bclk;
  wire line_a   = mso_pad.oe ? mso_pad.o : sdi;
  ssgc_channel dut_u (.core_clk(core_clk), .rstn(rstn), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slave_select_pin_n(sel_n), .trigger_input_pin_n(trg_n), .transfer_clock_pin_i(line_clk),
    .transfer_clock_pin_o(clk_pad), .slave_serial_in(line_a), .master_serial_out(mso_pad),
    .master_serial_in(miso), .slave_serial_out(sso_pad), .tx_irq(tx_irq), .rx_irq(rx_irq));
  ssgc_peer peer_u (.sclk(line_clk), .mosi(line_a), .miso(miso), .tx_byte(peer_tx),
    .rx_q(peer_rx));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (tx_irq === 1'b1) txn <= txn + 1;
    if (rx_irq === 1'b1) rxn <= rxn + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic nb(output logic [7:0] r);
    seed = xs(seed);
    r = seed[7:0];
  endtask
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // 80 ns external clock, data set ahead of each leading edge, device output taken there
  task automatic slave_xfer(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sdi <= b[i];
      repeat (10) @(posedge core_clk);
      bclk <= 1'b1;
      cap[i] = sso_pad.o;
      repeat (10) @(posedge core_clk);
      bclk <= 1'b0;
    end
    repeat (10) @(posedge core_clk);
  endtask
  task automatic wait_tx(input int n);
    int k;
    for (k = 0; k < 400 && txn == n; k++) @(posedge core_clk);
    if (k == 400) begin
      fail_count++;
      end_sim();
    end
  endtask
  initial begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    sel_n = 1'b1; trg_n = 1'b1; bclk = 1'b0; sdi = 1'b0; peer_tx = 8'h00; cap = 8'h00;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rd(ssgc_pkg::A_CH_CTRL0, v); chk(v, 16'h0008);
    rd(ssgc_pkg::A_CH_CTRL1, v); chk(v, 16'h0002);
    rd(4'hf, v); chk(v, 16'h0000);
    // master in select mode, select high, irq on completion
    wr(ssgc_pkg::A_BIT_RATE, 8'h03);
    wr(ssgc_pkg::A_CH_MODE, 8'h01);
    wr(ssgc_pkg::A_SPECIAL3, 8'h01);
    wr(ssgc_pkg::A_CH_CTRL1, 8'h15);
    nb(t); nb(peer_tx);
    wr(ssgc_pkg::A_TX_BUFFER, t);
    wait_tx(txn);
    chk(peer_rx, t);
    rd(ssgc_pkg::A_RX_BUFFER, v); chk(v, {8'h00, peer_tx});
    // another master takes the bus
    sel_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk(clk_pad.oe, 1'b0);
    chk(mso_pad.oe, 1'b0);
    rd(ssgc_pkg::A_SPECIAL3, v); chk(v, 16'h0005);
    sel_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(clk_pad.oe, 1'b0);
    wr(ssgc_pkg::A_SPECIAL3, 8'h01);
    repeat (3) @(posedge core_clk);
    chk({clk_pad.oe, mso_pad.oe}, 2'h3);
    // slave, phase 1, external clock
    wr(ssgc_pkg::A_CH_MODE, 8'h09);
    wr(ssgc_pkg::A_SPECIAL3, 8'h0b);
    wr(ssgc_pkg::A_CH_CTRL1, 8'h05);
    nb(t); wr(ssgc_pkg::A_TX_BUFFER, t);
    repeat (4) @(posedge core_clk);
    chk(sso_pad.oe, 1'b0);
    r0 = rxn; nb(a); slave_xfer(a);
    chk(rxn - r0, 0);
    sel_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk({sso_pad.oe, sso_pad.o}, {1'b1, t[0]});
    nb(a); slave_xfer(a);
    chk(cap, t);
    chk(rxn - r0, 1);
    nb(t); wr(ssgc_pkg::A_TX_BUFFER, t);
    nb(a); slave_xfer(a);
    chk(rxn - r0, 1);
    rd(ssgc_pkg::A_RX_BUFFER, v); chk(v[12], 1'b1);
    wr(ssgc_pkg::A_CH_CTRL1, 8'h01);
    wr(ssgc_pkg::A_CH_CTRL1, 8'h05);
    nb(t); wr(ssgc_pkg::A_TX_BUFFER, t);
    nb(a); slave_xfer(a);
    rd(ssgc_pkg::A_RX_BUFFER, v); chk(v, {8'h00, a});
    // trigger-synchronised mode, own output looped back on pad a
    wr(ssgc_pkg::A_SPECIAL3, 8'h00);
    wr(ssgc_pkg::A_SPECIAL2, 8'h40);
    wr(ssgc_pkg::A_CH_MODE, 8'h09);
    nb(t); wr(ssgc_pkg::A_TX_BUFFER, t);
    r0 = txn;
    repeat (8) @(posedge core_clk);
    rd(ssgc_pkg::A_CH_CTRL0, v); chk(v, 16'h0008);
    chk(txn - r0, 0);
    trg_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    trg_n <= 1'b1;
    nb(a); slave_xfer(a);
    chk(txn - r0, 1);
    rd(ssgc_pkg::A_RX_BUFFER, v); chk(v, {8'h00, t});
    // half rate: one external period per transfer edge
    wr(ssgc_pkg::A_SPECIAL1, 8'h80);
    nb(t); wr(ssgc_pkg::A_TX_BUFFER, t);
    r0 = rxn; slave_xfer(a);
    chk(rxn - r0, 0);
    slave_xfer(a);
    chk(rxn - r0, 1);
    rd(ssgc_pkg::A_RX_BUFFER, v); chk(v, {8'h00, t});
    end_sim();
  end
endmodule
